// [verilog/pllo_ctrl.sv]
// Overview of operation
// - Pin decides output; enable bit shows pin
// - Override set: enable bit drives the output
// - Output off while its PLL powered down
// - PLL1 from pin, or bit 1 when overridden
// - PLL2 powered by bit 3 with bit 2
// - Override and enable both one turn on
// - Override bits load from the OTP image
// - OTP override one disconnects pin for good
// - Hold static levels 2 us before toggling
// - Stop switching first, then bias off, high-Z
// - Two-bit format per driver, low byte
// - CMOS drives true pin only, complement high-Z
// - CMOS default; all formats in one write
// - 444-bit OTP loads at power-up, host overwrites
// - PLL1 takes reference 2 only when selected
module pllo_ctrl
    import pllo_pkg::*;
#(
    parameter logic [OTP_BITS-1:0] OTP_IMAGE = OTP_DEFAULT
) (
    input wire logic CORE_CLK_I,                 // 100 MHz core clock
    input wire logic RSTN_I,                     // Async reset, active low
    input wire logic CE_I,                       // Clock enable
    input wire logic [NUM_OUT-1:0] OE_PIN_I,     // Output enable pins
    input wire logic PLL1_PD_PIN_N_I,            // PLL1 power-down pin
    input wire logic REG_WR_I,                   // Register write strobe
    input wire logic REG_RD_I,                   // Register read strobe
    input wire logic [REG_IDX_W-1:0] REG_IDX_I,  // Register number
    input wire logic [PLL_OE_W-1:0] REG_WDATA_I, // Write data
    output logic [PLL_OE_W-1:0] REG_RDATA_O,     // Read data
    output logic PLL1_PWR_O,                     // PLL1 powered
    output logic PLL2_PWR_O,                     // PLL2 powered
    output logic PLL1_REF2_SEL_O,                // PLL1 uses reference 2
    output logic [NUM_OUT*FMT_W-1:0] DRV_FMT_O,  // Driver formats
    output logic [NUM_OUT-1:0] DRV_BIAS_O,       // Driver bias on
    output logic [NUM_OUT-1:0] DRV_TOGGLE_O,     // Driver switching
    output logic [NUM_OUT-1:0] DRV_TRUE_OE_O,    // True pin driven
    output logic [NUM_OUT-1:0] DRV_COMP_OE_O     // Complement pin driven
);

    localparam logic [PLL_OE_W-1:0] PLL_OE_INIT =
        OTP_IMAGE[OTP_PLL_OE_POS +: PLL_OE_W];
    localparam logic [FMT_REG_W-1:0] FMT_INIT =
        OTP_IMAGE[OTP_FMT_POS +: FMT_REG_W];

    logic [4:0] sync1_q, sync1_d, sync2_q, sync2_d, sync3_q, sync3_d;
    logic [4:0] pin_q, pin_d;
    logic [PLL_OE_W-1:0] pll_oe_q, pll_oe_d, rd_view;
    logic [FMT_REG_W-1:0] fmt_reg_q, fmt_reg_d;
    logic [PLL_OE_W-1:0] rdata_q, rdata_d;
    logic [NUM_OUT-1:0] otp_lock, drv_req, drv_en;
    logic pll1_up, pll2_up, ref2_sel;
    logic pll1_pwr_q, pll2_pwr_q, ref2_q;
    logic [NUM_OUT*FMT_W-1:0] fmt_q;

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    // Three stages; a level is taken only once stages two and three agree,
    // which also rejects a single-cycle spike on the pin
    always_comb begin
        sync1_d = {PLL1_PD_PIN_N_I, OE_PIN_I};
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        pin_d = pin_q;
        for (int i = 0; i < 5; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                pin_d[i] = sync3_q[i];
            end
        end
    end

    // Reset to the pulled-up level of the pins
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sync1_q <= PIN_RESET;
            sync2_q <= PIN_RESET;
            sync3_q <= PIN_RESET;
            pin_q <= PIN_RESET;
        end else if (CE_I) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            pin_q <= pin_d;
        end
    end

    // ********************************************************************
    // Control decode
    // ********************************************************************
    // Effective enables, PLL power and the read view of the enable bits
    always_comb begin
        pll1_up = pll_oe_q[PLL1_OVR_BIT] ? pll_oe_q[PLL1_BIT] : pin_q[4];
        pll2_up = pll_oe_q[PLL2_EN_BIT] && pll_oe_q[PLL2_BIT];
        ref2_sel = pll_oe_q[PLL1_REF_OVR_BIT] && pll_oe_q[PLL1_REF_BIT];
        rd_view = pll_oe_q;
        for (int i = 0; i < NUM_OUT; i++) begin
            otp_lock[i] = PLL_OE_INIT[OE_OVR_BASE + 2*i];
            if (pll_oe_q[OE_OVR_BASE + 2*i]) begin
                drv_req[i] = pll_oe_q[DRV_ON_BASE + 2*i];
            end else begin
                drv_req[i] = pin_q[i];
                rd_view[DRV_ON_BASE + 2*i] = pin_q[i];
            end
            // Outputs 1 and 2 hang on PLL1, 3 and 4 on PLL2
            drv_en[i] = drv_req[i] && ((i < PLL1_OUTS) ? pll1_up : pll2_up);
        end
    end

    // ********************************************************************
    // Register file
    // ********************************************************************
    // A write under pin control still stores the enable bit, so it takes
    // effect only if software later sets the override
    always_comb begin
        pll_oe_d = pll_oe_q;
        fmt_reg_d = fmt_reg_q;
        rdata_d = rdata_q;
        if (REG_WR_I && REG_IDX_I == REG_PLL_OE_IDX) begin
            pll_oe_d = REG_WDATA_I;
            for (int i = 0; i < NUM_OUT; i++) begin
                if (otp_lock[i]) begin
                    pll_oe_d[OE_OVR_BASE + 2*i] = 1'b1;
                end
            end
        end else if (REG_WR_I && REG_IDX_I == REG_FMT_IDX) begin
            fmt_reg_d = REG_WDATA_I[FMT_REG_W-1:0];
        end
        if (REG_RD_I && REG_IDX_I == REG_PLL_OE_IDX) begin
            rdata_d = rd_view;
        end else if (REG_RD_I && REG_IDX_I == REG_FMT_IDX) begin
            rdata_d = {{(PLL_OE_W-FMT_REG_W){1'b0}}, fmt_reg_q};
        end else if (REG_RD_I) begin
            rdata_d = '0;
        end
    end

    // Reset loads the stored image, the power-up configuration
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pll_oe_q <= PLL_OE_INIT;
            fmt_reg_q <= FMT_INIT;
            rdata_q <= '0;
        end else if (CE_I) begin
            pll_oe_q <= pll_oe_d;
            fmt_reg_q <= fmt_reg_d;
            rdata_q <= rdata_d;
        end
    end

    // ********************************************************************
    // Registered outputs
    // ********************************************************************
    // PLL power, reference select and driver formats
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pll1_pwr_q <= 1'b0;
            pll2_pwr_q <= 1'b0;
            ref2_q <= 1'b0;
            fmt_q <= '0;
        end else if (CE_I) begin
            pll1_pwr_q <= pll1_up;
            pll2_pwr_q <= pll2_up;
            ref2_q <= ref2_sel;
            fmt_q <= fmt_reg_q[FMT_BASE +: NUM_OUT*FMT_W];
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign PLL1_PWR_O = pll1_pwr_q;
    assign PLL2_PWR_O = pll2_pwr_q;
    assign PLL1_REF2_SEL_O = ref2_q;
    assign DRV_FMT_O = fmt_q;

    // ********************************************************************
    // Driver sequencers
    // ********************************************************************
    pllo_drv_if drv_if[NUM_OUT] ();

    for (genvar g = 0; g < NUM_OUT; g++) begin : g_drv
        assign drv_if[g].enable = drv_en[g];
        assign drv_if[g].fmt = fmt_q[FMT_W*g +: FMT_W];
        pllo_drv_seq u_seq (
            .clk_i (CORE_CLK_I),
            .rstn_i (RSTN_I),
            .ce_i (CE_I),
            .bus (drv_if[g])
        );
        assign DRV_BIAS_O[g] = drv_if[g].bias;
        assign DRV_TOGGLE_O[g] = drv_if[g].toggle;
        assign DRV_TRUE_OE_O[g] = drv_if[g].true_oe;
        assign DRV_COMP_OE_O[g] = drv_if[g].comp_oe;
    end

    pin_readback_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I && REG_RD_I && REG_IDX_I == REG_PLL_OE_IDX
        && !pll_oe_q[OE_OVR_BASE]
        |=> REG_RDATA_O[DRV_ON_BASE] == $past(pin_q[0]))
        else $error("enable bit does not show pin level");

    forced_off_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I && pll_oe_q[OE_OVR_BASE] && !pll_oe_q[DRV_ON_BASE]
        |=> !DRV_TOGGLE_O[0])
        else $error("forced-off output still switching");

    pll_gate_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I && !pll2_up |=> !DRV_TOGGLE_O[2] && !DRV_TOGGLE_O[3])
        else $error("output switching with its pll down");

    pll1_power_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I && !pll_oe_q[PLL1_OVR_BIT] |=> PLL1_PWR_O == $past(pin_q[4]))
        else $error("pll1 power does not follow pin");

    pll2_power_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I |=> PLL2_PWR_O ==
        $past(pll_oe_q[PLL2_EN_BIT] && pll_oe_q[PLL2_BIT]))
        else $error("pll2 power does not follow bits");

    otp_lock_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        otp_lock[0] |-> pll_oe_q[OE_OVR_BASE])
        else $error("locked override bit was cleared");

    fmt_write_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I && REG_WR_I && REG_IDX_I == REG_FMT_IDX ##1 CE_I
        |=> DRV_FMT_O == $past(REG_WDATA_I[NUM_OUT*FMT_W-1:0], 2))
        else $error("formats not taken from one write");

    ref_select_a: assert property (
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        CE_I |=> PLL1_REF2_SEL_O ==
        $past(pll_oe_q[PLL1_REF_OVR_BIT] && pll_oe_q[PLL1_REF_BIT]))
        else $error("pll1 reference select wrong");

endmodule // pllo_ctrl

// [verilog/pllo_pkg.sv]
package pllo_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_US = 2;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_TIME_NS = 20;
    localparam int STOP_CYCLES =
        (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // ********************************************************************
    // Register map and field positions
    // ********************************************************************
    localparam int NUM_OUT = 4;
    localparam int REG_IDX_W = 4;
    localparam logic [REG_IDX_W-1:0] REG_PLL_OE_IDX = 4'h2;
    localparam logic [REG_IDX_W-1:0] REG_FMT_IDX = 4'h4;
    localparam int PLL_OE_W = 24;
    localparam int FMT_REG_W = 16;
    localparam int PLL1_OVR_BIT = 0;
    localparam int PLL1_BIT = 1;
    localparam int PLL2_EN_BIT = 2;
    localparam int PLL2_BIT = 3;
    localparam int PLL1_REF_OVR_BIT = 4;
    localparam int PLL1_REF_BIT = 5;
    localparam int OE_OVR_BASE = 8;
    localparam int DRV_ON_BASE = 9;
    localparam int FMT_BASE = 0;
    localparam int FMT_W = 2;
    localparam int PLL1_OUTS = 2;

    // ********************************************************************
    // One-time-programmable store layout and default image
    // ********************************************************************
    localparam int OTP_BITS = 444;
    localparam int OTP_PLL_OE_POS = 0;
    localparam int OTP_FMT_POS = 24;
    localparam logic [OTP_BITS-1:0] OTP_DEFAULT = 444'h00C;
    localparam logic [4:0] PIN_RESET = 5'h1F;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        FMT_CMOS = 2'b00,
        FMT_LVDS = 2'b01,
        FMT_LVPECL = 2'b10,
        FMT_HCSL = 2'b11
    } pllo_fmt_e;

    typedef enum logic [1:0] {
        DRV_OFF = 2'b00,
        DRV_SETTLE = 2'b01,
        DRV_RUN = 2'b10,
        DRV_STOP = 2'b11
    } pllo_drv_state_e;

endpackage

// [verilog/pllo_drv_if.sv]
interface pllo_drv_if;
    logic enable;
    logic [1:0] fmt;
    logic bias;
    logic toggle;
    logic true_oe;
    logic comp_oe;
    modport ctrl (output enable, output fmt, input bias, input toggle,
                  input true_oe, input comp_oe);
    modport drv (input enable, input fmt, output bias, output toggle,
                 output true_oe, output comp_oe);
endinterface

// [verilog/pllo_drv_seq.sv]
module pllo_drv_seq
    import pllo_pkg::*;
(
    input wire logic clk_i,    // Core clock
    input wire logic rstn_i,   // Async reset, active low
    input wire logic ce_i,     // Clock enable
    pllo_drv_if.drv bus        // Enable request and driver controls
);

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] STOP_LAST = CNT_W'(STOP_CYCLES - 1);

    pllo_drv_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic bias_q, bias_d, toggle_q, toggle_d;
    logic true_oe_q, true_oe_d, comp_oe_q, comp_oe_d;
    logic [CNT_W-1:0] quiet_q, quiet_d;

    // ********************************************************************
    // Enable and disable sequencing
    // ********************************************************************
    // Next state; a drop of enable during settling still goes via stop
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            DRV_OFF: begin
                if (bus.enable) begin
                    state_d = DRV_SETTLE;
                    cnt_d = '0;
                end
            end
            DRV_SETTLE: begin
                if (!bus.enable) begin
                    state_d = DRV_STOP;
                    cnt_d = '0;
                end else if (cnt_q == SETTLE_LAST) begin
                    state_d = DRV_RUN;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            DRV_RUN: begin
                if (!bus.enable) begin
                    state_d = DRV_STOP;
                    cnt_d = '0;
                end
            end
            DRV_STOP: begin
                if (cnt_q == STOP_LAST) begin
                    state_d = DRV_OFF;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: state_d = DRV_OFF;
        endcase
        bias_d = (state_d != DRV_OFF);
        toggle_d = (state_d == DRV_RUN);
        true_oe_d = bias_d;
        comp_oe_d = bias_d && (bus.fmt != FMT_CMOS);
        quiet_d = (!bias_q) ? '0 :
                  (toggle_q || quiet_q == '1) ? quiet_q : quiet_q + 1'b1;
    end

    // Controls are registered so the pins never see decode glitches
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= DRV_OFF;
            cnt_q <= '0;
            bias_q <= 1'b0;
            toggle_q <= 1'b0;
            true_oe_q <= 1'b0;
            comp_oe_q <= 1'b0;
            quiet_q <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bias_q <= bias_d;
            toggle_q <= toggle_d;
            true_oe_q <= true_oe_d;
            comp_oe_q <= comp_oe_d;
            quiet_q <= quiet_d;
        end
    end

    assign bus.bias = bias_q;
    assign bus.toggle = toggle_q;
    assign bus.true_oe = true_oe_q;
    assign bus.comp_oe = comp_oe_q;

    settle_time_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(toggle_q) |-> quiet_q >= CNT_W'(SETTLE_CYCLES))
        else $error("driver toggled before settle time");

    stop_order_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $fell(bias_q) |-> !$past(toggle_q) && !toggle_q && !true_oe_q)
        else $error("bias removed while switching");

    cmos_comp_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && bus.fmt == FMT_CMOS |=> !comp_oe_q)
        else $error("complement pin driven in cmos format");

endmodule // pllo_drv_seq

// [test/pllo_host_model.sv]
module pllo_host_model
    import pllo_pkg::*;
(
    input wire logic clk_i,                    // Core clock
    input wire logic rstn_i,                   // Reset, active low
    output logic wr_o,                         // Write strobe
    output logic rd_o,                         // Read strobe
    output logic [REG_IDX_W-1:0] idx_o,        // Register number
    output logic [PLL_OE_W-1:0] wdata_o,       // Write data
    input wire logic [PLL_OE_W-1:0] rdata_i    // Read data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Idle bus
    // ****************************************************************
    // Strobes low from time zero so nothing is taken during reset
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        idx_o = 4'h0;
        wdata_o = 24'h000000;
    end

    // No access before the device has left reset
    task automatic wait_ready();
        while (rstn_i !== 1'b1) @(posedge clk_i);
    endtask

    // One-cycle write strobe, data inverted once released
    task automatic wr(input logic [REG_IDX_W-1:0] idx,
                      input logic [PLL_OE_W-1:0] data);
        logic [PLL_OE_W-1:0] d;
        d = data;
        if (idx === REG_PLL_OE_IDX) d[PLL2_EN_BIT] = 1'b1;
        wait_ready();
        @(posedge clk_i);
        wr_o <= 1'b1;
        idx_o <= idx;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d; // Stale data would hide a late sample
    endtask

    // Read data is registered and holds, so take it one edge later
    task automatic rd(input logic [REG_IDX_W-1:0] idx,
                      output logic [PLL_OE_W-1:0] data);
        wait_ready();
        @(posedge clk_i);
        rd_o <= 1'b1;
        idx_o <= idx;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        #1;
        data = rdata_i;
    endtask
endmodule // pllo_host_model

// [test/pll_output_enable_control_tb.sv]
`define CHK(nm, ex, gt) \
    begin \
        checks_done++; \
        if ((gt) !== (ex)) begin \
            mismatches++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end

module pll_output_enable_control_tb
    import pllo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk, rstn, ce, pd_n, wr, rd, pll1, pll2, ref2;
    logic [3:0] pins, bias, tog, toe, coe, bias2;
    logic [3:0] idx;
    logic [23:0] wdata, rdata, rdata2, rv, r2;
    logic [7:0] fmt;
    int mismatches = 0;
    int checks_done = 0;
    int n;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    pllo_host_model host_u (.clk_i(clk), .rstn_i(rstn), .wr_o(wr),
        .rd_o(rd), .idx_o(idx), .wdata_o(wdata), .rdata_i(rdata));

    pllo_ctrl dut_u (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
        .OE_PIN_I(pins), .PLL1_PD_PIN_N_I(pd_n), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_IDX_I(idx), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .PLL1_PWR_O(pll1), .PLL2_PWR_O(pll2),
        .PLL1_REF2_SEL_O(ref2), .DRV_FMT_O(fmt), .DRV_BIAS_O(bias),
        .DRV_TOGGLE_O(tog), .DRV_TRUE_OE_O(toe), .DRV_COMP_OE_O(coe));

    // Second device whose image locks output 1 under override, enabled at reset
    pllo_ctrl #(.OTP_IMAGE(444'h30C)) dut2_u (.CORE_CLK_I(clk),
        .RSTN_I(rstn), .CE_I(ce), .OE_PIN_I(pins),
        .PLL1_PD_PIN_N_I(pd_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_IDX_I(idx), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata2),
        .PLL1_PWR_O(), .PLL2_PWR_O(), .PLL1_REF2_SEL_O(),
        .DRV_FMT_O(), .DRV_BIAS_O(bias2), .DRV_TOGGLE_O(),
        .DRV_TRUE_OE_O(), .DRV_COMP_OE_O());

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Read view: enable bits under pin control show the pin
    function automatic logic [23:0] view(logic [23:0] r, logic [3:0] p);
        logic [23:0] v;
        v = r;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (!r[OE_OVR_BASE+2*i]) v[DRV_ON_BASE+2*i] = p[i];
        end
        return v;
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs about 4 us
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        pins = 4'hF;
        pd_n = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // Power-up image: all outputs on by pin, then settle delay
        n = 0;
        while (bias !== 4'hF && n < 50) begin step(1); n++; end
        `CHK("bias up", 4'hF, bias);
        `CHK("true oe", 4'hF, toe);
        `CHK("comp oe", 4'h0, coe);
        n = 0;
        while (tog[0] !== 1'b1 && n < 400) begin step(1); n++; end
        `CHK("settle", SETTLE_CYCLES, n);
        `CHK("toggle", 4'hF, tog);
        `CHK("fmt reset", 8'h00, fmt);
        `CHK("pll1 pin", 1'b1, pll1);
        `CHK("pll2 on", 1'b1, pll2);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("reg2 reset", view(OTP_DEFAULT[23:0], 4'hF), rv);
        host_u.rd(REG_FMT_IDX, rv);
        `CHK("reg4 reset", 24'h000000, rv);
        // Pin drop: switching stops before bias goes
        @(posedge clk);
        pins <= 4'hD;
        n = 0;
        while (tog[1] !== 1'b0 && n < 20) begin step(1); n++; end
        `CHK("static stop", 1'b1, bias[1]);
        n = 0;
        while (bias[1] !== 1'b0 && n < 20) begin step(1); n++; end
        `CHK("stop hold", STOP_CYCLES, n);
        `CHK("true oe off", 4'hD, toe);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("reg2 pins", view(24'h00000C, 4'hD), rv);
        // Enable write under pin control leaves output and read view on the pin
        host_u.wr(REG_PLL_OE_IDX, 24'h00080C);
        step(8);
        `CHK("pin kept", 4'hD, bias);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("reg2 track", view(24'h00080C, 4'hD), rv);
        // Override on and forced off
        r2 = 24'h000C0C;
        host_u.wr(REG_PLL_OE_IDX, r2);
        step(8);
        `CHK("forced on", 4'hF, bias);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("reg2 ovr", view(r2, 4'hD), rv);
        host_u.wr(REG_PLL_OE_IDX, 24'h000D0C);
        step(8);
        `CHK("forced off", 4'hE, bias);
        // PLL1 by pin, then by bits with the pin ignored
        @(posedge clk);
        pd_n <= 1'b0;
        step(8);
        `CHK("pll1 pd", 1'b0, pll1);
        `CHK("pll1 outs off", 4'hC, bias);
        host_u.wr(REG_PLL_OE_IDX, 24'h000D0F);
        step(8);
        `CHK("pll1 bit on", 1'b1, pll1);
        `CHK("pll1 outs on", 4'hE, bias);
        @(posedge clk);
        pd_n <= 1'b1;
        host_u.wr(REG_PLL_OE_IDX, 24'h000D0D);
        step(8);
        `CHK("pll1 bit off", 1'b0, pll1);
        host_u.wr(REG_PLL_OE_IDX, 24'h000D0C);
        step(8);
        `CHK("pll1 pin up", 1'b1, pll1);
        // PLL2 by bit 3, with bit 2 held set by the host
        host_u.wr(REG_PLL_OE_IDX, 24'h000D04);
        step(8);
        `CHK("pll2 off", 1'b0, pll2);
        `CHK("pll2 outs off", 4'h2, bias);
        host_u.wr(REG_PLL_OE_IDX, 24'h000D0C);
        step(8);
        `CHK("pll2 on again", 1'b1, pll2);
        // All four formats in one write
        host_u.wr(REG_FMT_IDX, 24'h00ABE4);
        step(8);
        `CHK("fmt", 8'hE4, fmt);
        `CHK("comp diff", 4'hE, coe);
        host_u.rd(REG_FMT_IDX, rv);
        `CHK("reg4", 24'h00ABE4, rv);
        // Clock enable low: a write is not taken and drivers hold
        @(posedge clk);
        ce <= 1'b0;
        host_u.wr(REG_FMT_IDX, 24'h000000);
        step(4);
        `CHK("ce fmt", 8'hE4, fmt);
        `CHK("ce bias", 4'hE, bias);
        @(posedge clk);
        ce <= 1'b1;
        // Reference select needs both bits
        for (int i = 0; i < 3; i++) begin
            r2 = (i == 0) ? 24'h000D3C : (i == 1) ? 24'h000D1C : 24'h000D2C;
            host_u.wr(REG_PLL_OE_IDX, r2);
            step(8);
            `CHK("ref2", (i == 0), ref2);
        end
        // Unmapped register reads zero and ignores writes
        host_u.rd(4'h7, rv);
        `CHK("unmapped", 24'h000000, rv);
        host_u.wr(4'h7, 24'hFFFFFF);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("reg2 kept", view(r2, 4'hD), rv);
        // Image override cannot be cleared and pin is cut off
        host_u.wr(REG_PLL_OE_IDX, 24'h00020C);
        @(posedge clk);
        pins <= 4'hC;
        step(8);
        `CHK("otp on", 1'b1, bias2[0]);
        `CHK("pin off", 1'b0, bias[0]);
        host_u.rd(REG_PLL_OE_IDX, rv);
        `CHK("otp ovr kept", view(24'h00030C, 4'hC), rdata2);
        `CHK("reg2 final", view(24'h00020C, 4'hC), rv);
        finish_test();
    end
endmodule // pll_output_enable_control_tb
